// ===== design/bus_interface_prefetch_unit.sv
// bus interface unit: address adder, bus cycles, prefetch queue
// assumes: execution unit logic on clk_sys_i; bus pins asynchronous
//
// What this block does
// [RQ1] drive 20-bit physical address every memory access
// [RQ2] wide 16-bit data bus, narrow 8-bit
// [RQ3] minimum mode: unit drives all bus controls
// [RQ4] maximum mode: external controller, pins give status
// [RQ5] queue holds six bytes wide, four narrow
// [RQ6] dedicated adder forms address from segment, offset
// [RQ7] execution unit stalls on an empty queue
// [RQ8] memory and port accesses become bus requests
// [RQ9] wide: prefetch needs two free, no request
// [RQ10] narrow: prefetch when one byte is free
// [RQ11] prefetch loads two bytes wide at an even pointer, otherwise one
// [RQ12] running prefetch finishes before a request
// [RQ13] execution unit supplies addresses and data
// [RQ14] only this unit runs external bus cycles
// [RQ15] bus cycle at least four states, address first
// [RQ16] idle states when no cycle is needed
// [RQ17] bus data held steady during wait states
// [RQ18] jump empties queue, refill from target
// [RQ19] reset empties queue and drops pending request
`timescale 1ns/1ns
`default_nettype none
module bus_interface_prefetch_unit #(
	parameter bit WIDE = 1'b1,
	parameter logic [15:0] RESET_SEG = 16'h0000,
	parameter logic [15:0] RESET_OFF = 16'h0000
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// strap and wait pins
	input wire logic bus_mode_strap_i,
	input wire logic ready_i,
	// multiplexed address and data bus
	input wire logic [15:0] ad_i,
	output logic [15:0] ad_o,
	output logic ad_oe_o,
	output logic ad_hi_oe_o,
	output logic [3:0] addr_hi_o,
	output logic bhe_n_o,
	// bus control pins
	output logic ale_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic mem_io_o,
	output logic dt_r_o,
	output logic den_n_o,
	output logic ctl_oe_o,
	output logic [2:0] status_o,
	// instruction bytes to the execution unit
	output logic fetch_valid_o,
	output logic [7:0] fetch_byte_o,
	input wire logic fetch_ready_i,
	// program jump
	input wire logic jump_i,
	input wire logic [15:0] jump_seg_i,
	input wire logic [15:0] jump_off_i,
	// data bus requests from the execution unit
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_write_i,
	input wire logic req_io_i,
	input wire logic req_word_i,
	input wire logic [15:0] req_seg_i,
	input wire logic [15:0] req_off_i,
	input wire logic [15:0] req_wdata_i,
	// answers to the execution unit
	output logic rsp_valid_o,
	output logic [15:0] rsp_data_o,
	input wire logic rsp_ready_i
);
	import bpu_pkg::*;

	// ==========================================================
	// variant sizing
	// [RQ5] queue depth per variant
	localparam int QD = WIDE ? WIDE_QDEPTH : NARROW_QDEPTH;
	localparam logic [3:0] MIN_FREE = WIDE ? WIDE_MIN_FREE : NARROW_MIN_FREE;

	pfq_if qf ();

	// ==========================================================
	// pin synchronisers: strap, ready and data sampled together
	logic [17:0] s1_q;
	logic [17:0] s2_q;
	wire strap_s = s2_q[17];
	wire ready_s = s2_q[16];
	wire [15:0] ad_s = s2_q[15:0];

	logic [1:0] settle_q;
	logic strap_done_q;
	logic max_mode_q;

	// ==========================================================
	// bus engine state
	bus_state_e st_q;
	bus_state_e st_d;
	logic cy_fetch_q, cy_write_q, cy_io_q, cy_two_q, drop_q;
	logic cy_fetch_d, cy_write_d, cy_io_d, cy_two_d;
	logic [19:0] cy_addr_q;
	logic [19:0] cy_addr_d;
	logic [15:0] cy_wd_q;
	logic [15:0] cy_wd_d;
	logic [15:0] rdat_q;

	// pending execution unit request
	logic pend_q, p_write_q, p_io_q, p_word_q;
	logic [19:0] p_addr_q;
	logic [15:0] p_wd_q;

	// fetch pointer
	logic [15:0] fcs_q;
	logic [15:0] fip_q;

	logic rsp_in_ready;

	// ==========================================================
	// arbitration
	wire take_req = req_valid_i && req_ready_o;
	wire idle = st_q == ST_IDLE && strap_done_q;
	// [RQ8] data accesses wait for a free answer slot
	wire go_eu = idle && pend_q && rsp_in_ready;
	// [RQ9] [RQ10] prefetch gated by free bytes and request
	wire go_pf = idle && !pend_q && qf.free >= MIN_FREE && !jump_i;
	wire start = go_eu || go_pf;
	wire last_t = (st_q == ST_T3 || st_q == ST_TW) && ready_s;
	wire at_t4 = st_q == ST_T4;

	// [RQ11] two bytes per prefetch wide, unless pointer is odd
	wire fetch_two = WIDE && !fip_q[0];
	// [RQ6] fetch address from code segment and pointer
	wire [19:0] fetch_addr = bpu_pkg::phys_addr(fcs_q, fip_q);
	wire pf_land = at_t4 && cy_fetch_q && !drop_q && !jump_i;
	wire eu_land = at_t4 && !cy_fetch_q;
	wire hi_lane = WIDE && cy_addr_q[0];

	assign cy_fetch_d = go_eu ? 1'b0 : go_pf ? 1'b1 : cy_fetch_q;
	assign cy_write_d = go_eu ? p_write_q : go_pf ? 1'b0 : cy_write_q;
	assign cy_io_d = go_eu ? p_io_q : go_pf ? 1'b0 : cy_io_q;
	assign cy_two_d = go_eu ? p_word_q && WIDE : go_pf ? fetch_two
		: cy_two_q;
	assign cy_addr_d = go_eu ? p_addr_q : go_pf ? fetch_addr : cy_addr_q;
	assign cy_wd_d = go_eu ? p_wd_q : cy_wd_q;

	// ==========================================================
	// bus cycle sequence
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			// [RQ16] stay idle while nothing needs the bus
			ST_IDLE: begin
				if (start) begin
					st_d = ST_T1;
				end
			end
			// [RQ15] four states at least, address in the first
			ST_T1: st_d = ST_T2;
			ST_T2: st_d = ST_T3;
			// [RQ17] wait states until the device is ready
			ST_T3, ST_TW: st_d = ready_s ? ST_T4 : ST_TW;
			ST_T4: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	// ==========================================================
	// pin values for the coming state; registered below
	wire in_t1 = st_d == ST_T1;
	wire in_mid = st_d == ST_T2 || st_d == ST_T3 || st_d == ST_TW;
	wire busy_d = st_d != ST_IDLE;
	wire [15:0] ad_dat_d = cy_write_d ? cy_wd_d : 16'h0000;
	// [RQ2] narrow bus keeps upper address byte for the whole cycle
	wire [15:0] ad_d = in_t1 ? cy_addr_d[15:0]
		: WIDE ? ad_dat_d : {cy_addr_d[15:8], ad_dat_d[7:0]};
	wire adl_oe_d = in_t1 || (busy_d && cy_write_d);
	wire adh_oe_d = WIDE ? adl_oe_d : busy_d;
	wire bhe_n_d = !(busy_d && WIDE && (cy_two_d || cy_addr_d[0]));
	// [RQ3] [RQ4] minimum mode drives the controls itself
	wire min_m = strap_done_q && !max_mode_q;
	wire [2:0] code_d = cy_fetch_d ? STS_FETCH
		: cy_io_d ? (cy_write_d ? STS_IO_WR : STS_IO_RD)
		: (cy_write_d ? STS_MEM_WR : STS_MEM_RD);
	wire [2:0] sts_d = max_mode_q && (in_t1 || in_mid) ? code_d
		: STS_PASSIVE;

	// ==========================================================
	// answer data aligned to bit 0
	wire [15:0] rsp_word = cy_write_q ? 16'h0000
		: hi_lane ? {8'h00, rdat_q[15:8]}
		: cy_two_q ? rdat_q : {8'h00, rdat_q[7:0]};
	wire [15:0] pf_data = hi_lane ? {8'h00, rdat_q[15:8]} : rdat_q;

	// [RQ7] bytes reach the execution unit only from the queue
	assign qf.pop = fetch_ready_i && fetch_valid_o;
	assign qf.push = pf_land;
	assign qf.push_two = cy_two_q;
	assign qf.push_data = pf_data;
	// [RQ18] a jump discards queued bytes
	assign qf.flush = jump_i;
	assign fetch_valid_o = qf.head_valid;
	assign fetch_byte_o = qf.head_byte;

	prefetch_queue #(
		.QD(QD)
	) u_queue (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.q(qf.store)
	);

	// [RQ14] data reaches the execution unit only through this unit
	skid_buf2 #(
		.W(16)
	) u_rsp (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.in_valid_i(eu_land),
		.in_ready_o(rsp_in_ready),
		.in_data_i(rsp_word),
		.out_valid_o(rsp_valid_o),
		.out_ready_i(rsp_ready_i),
		.out_data_o(rsp_data_o)
	);

	// ==========================================================
	// synchronisers and strap capture
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= 18'h00000;
			s2_q <= 18'h00000;
		end else begin
			s1_q <= {bus_mode_strap_i, ready_i, ad_i};
			s2_q <= s1_q;
		end
	end

	// the strap is caught once, after the sync chain holds pin values
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			settle_q <= 2'h0;
			strap_done_q <= 1'b0;
			max_mode_q <= 1'b0;
		end else if (!strap_done_q) begin
			settle_q <= settle_q + 2'h1;
			if (settle_q == STRAP_SETTLE) begin
				strap_done_q <= 1'b1;
				max_mode_q <= !strap_s;
			end
		end
	end

	// ==========================================================
	// engine registers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			cy_fetch_q <= 1'b0;
			cy_write_q <= 1'b0;
			cy_io_q <= 1'b0;
			cy_two_q <= 1'b0;
			cy_addr_q <= 20'h00000;
			cy_wd_q <= 16'h0000;
			rdat_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			cy_fetch_q <= cy_fetch_d;
			cy_write_q <= cy_write_d;
			cy_io_q <= cy_io_d;
			cy_two_q <= cy_two_d;
			cy_addr_q <= cy_addr_d;
			cy_wd_q <= cy_wd_d;
			if (last_t) begin
				rdat_q <= ad_s;
			end
		end
	end

	// [RQ18] fetched bytes of a cycle overtaken by a jump are dropped
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			drop_q <= 1'b0;
		end else if (start) begin
			drop_q <= 1'b0;
		end else if (jump_i && st_q != ST_IDLE) begin
			drop_q <= 1'b1;
		end
	end

	// [RQ18] refill restarts at the jump target
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			fcs_q <= RESET_SEG;
			fip_q <= RESET_OFF;
		end else if (jump_i) begin
			fcs_q <= jump_seg_i;
			fip_q <= jump_off_i;
		end else if (pf_land) begin
			fip_q <= fip_q + (cy_two_q ? WIDE_STEP : NARROW_STEP);
		end
	end

	// ==========================================================
	// request latch
	// [RQ13] address and data supplied by the execution unit
	// [RQ19] reset drops any pending request
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pend_q <= 1'b0;
			req_ready_o <= 1'b0;
			p_write_q <= 1'b0;
			p_io_q <= 1'b0;
			p_word_q <= 1'b0;
			p_addr_q <= 20'h00000;
			p_wd_q <= 16'h0000;
		end else begin
			pend_q <= take_req || (pend_q && !go_eu);
			req_ready_o <= !(take_req || (pend_q && !go_eu));
			if (take_req) begin
				p_write_q <= req_write_i;
				p_io_q <= req_io_i;
				p_word_q <= req_word_i;
				p_addr_q <= req_io_i ? {4'h0, req_off_i}
					: bpu_pkg::phys_addr(req_seg_i, req_off_i);
				p_wd_q <= WIDE && req_off_i[0]
					? {req_wdata_i[7:0], 8'h00} : req_wdata_i;
			end
		end
	end

	// ==========================================================
	// registered pins
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ad_o <= 16'h0000;
			ad_oe_o <= 1'b0;
			ad_hi_oe_o <= 1'b0;
			addr_hi_o <= 4'h0;
			bhe_n_o <= 1'b1;
			ale_o <= 1'b0;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			mem_io_o <= 1'b0;
			dt_r_o <= 1'b0;
			den_n_o <= 1'b1;
			ctl_oe_o <= 1'b0;
			status_o <= STS_PASSIVE;
		end else begin
			ad_o <= ad_d;
			ad_oe_o <= adl_oe_d;
			ad_hi_oe_o <= adh_oe_d;
			addr_hi_o <= busy_d ? cy_addr_d[19:16] : 4'h0;
			bhe_n_o <= bhe_n_d;
			ale_o <= in_t1 && min_m;
			rd_n_o <= !(in_mid && !cy_write_d);
			wr_n_o <= !(in_mid && cy_write_d && min_m);
			mem_io_o <= busy_d && !cy_io_d && min_m;
			dt_r_o <= busy_d && cy_write_d && min_m;
			den_n_o <= !(in_mid && min_m);
			ctl_oe_o <= min_m;
			status_o <= sts_d;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// [RQ15] cycle length
	cyc_len_a: assert property ( // [RQ15]
		st_q == ST_T1 |=> st_q == ST_T2 ##1 st_q == ST_T3
			##1 (st_q == ST_T4 || st_q == ST_TW))
		else $error("bus cycle shorter than four states");

	// [RQ1] address in first state
	addr_t1_a: assert property ( // [RQ1]
		st_q == ST_T1 |-> ad_oe_o && {addr_hi_o, ad_o[15:8]} ==
			cy_addr_q[19:8] && (!WIDE || ad_o[7:0] == cy_addr_q[7:0]))
		else $error("address missing in first state");

	// [RQ17] steady data in waits
	wait_hold_a: assert property ( // [RQ17]
		st_q == ST_TW |-> $stable(ad_o) && $stable(ad_oe_o)
			&& $stable(rd_n_o) && $stable(wr_n_o))
		else $error("bus changed during a wait state");

	// [RQ9] prefetch start gate
	pf_gate_a: assert property ( // [RQ9]
		$rose(st_q == ST_T1) && cy_fetch_q |-> !$past(pend_q)
			&& $past(qf.free) >= MIN_FREE)
		else $error("prefetch started without room");

	// [RQ12] no preemption
	no_preempt_a: assert property ( // [RQ12]
		cy_fetch_q && st_q != ST_IDLE && st_q != ST_T4 |=> cy_fetch_q)
		else $error("prefetch cycle preempted");

	// [RQ7] byte held until taken
	fetch_hold_a: assert property ( // [RQ7]
		fetch_valid_o && !fetch_ready_i && !jump_i |=> fetch_valid_o
			&& $stable(fetch_byte_o))
		else $error("queued byte lost before the fetch");

	// [RQ18] jump empties queue
	jump_flush_a: assert property ( // [RQ18]
		jump_i |=> !fetch_valid_o)
		else $error("queue not emptied by a jump");

	// [RQ3] controls by mode
	mode_ctl_a: assert property ( // [RQ3]
		strap_done_q && $past(strap_done_q) |-> ctl_oe_o == !max_mode_q
			&& (ctl_oe_o || (!ale_o && wr_n_o && den_n_o)))
		else $error("bus controls driven in the wrong mode");

	// [RQ16] pins quiet when idle
	idle_pins_a: assert property ( // [RQ16]
		st_q == ST_IDLE |-> rd_n_o && wr_n_o && !ad_oe_o && !ale_o)
		else $error("bus active in an idle state");

	// [RQ8] request taken once
	req_take_a: assert property ( // [RQ8]
		req_valid_i && req_ready_o |=> pend_q && !req_ready_o)
		else $error("accepted request not held pending");

endmodule // bus_interface_prefetch_unit
`default_nettype wire

// ===== design/prefetch_queue.sv
// instruction byte queue: shift register, head always in entry 0
// assumes: the filler never pushes more bytes than free reports
`timescale 1ns/1ns
`default_nettype none
module prefetch_queue #(
	parameter int QD = bpu_pkg::WIDE_QDEPTH
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// queue port
	pfq_if.store q
);
	if (QD < 2 || QD > 15) begin : g_chk
		$error("prefetch_queue: depth out of range");
	end

	logic [7:0] mem_q [QD];
	logic [7:0] mem_d [QD];
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [3:0] base;
	logic hv_q;

	assign q.free = 4'(QD) - cnt_q;
	assign q.head_valid = hv_q;
	assign q.head_byte = mem_q[0];

	always_comb begin
		mem_d = mem_q;
		base = cnt_q;
		if (q.pop && cnt_q != 4'h0) begin
			for (int i = 0; i < QD - 1; i++) begin
				mem_d[i] = mem_q[i + 1];
			end
			base = cnt_q - 4'h1;
		end
		if (q.push) begin
			for (int i = 0; i < QD; i++) begin
				if (4'(i) == base) begin
					mem_d[i] = q.push_data[7:0];
				end
				if (q.push_two && 4'(i) == base + 4'h1) begin
					mem_d[i] = q.push_data[15:8];
				end
			end
		end
		cnt_d = base + {3'h0, q.push} + {3'h0, q.push && q.push_two};
		// a flush drops everything, including a same-cycle push
		if (q.flush) begin
			cnt_d = 4'h0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < QD; i++) begin
				mem_q[i] <= 8'h00;
			end
			cnt_q <= 4'h0;
			hv_q <= 1'b0;
		end else begin
			mem_q <= mem_d;
			cnt_q <= cnt_d;
			hv_q <= cnt_d != 4'h0;
		end
	end
endmodule // prefetch_queue
`default_nettype wire

// ===== design/skid_buf2.sv
// two-entry buffer, valid and ready on both sides, outputs from flops
// assumes: one clock; the receiver may stall for any time
`timescale 1ns/1ns
`default_nettype none
module skid_buf2 #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	if (W < 1) begin : g_chk
		$error("skid_buf2: width must be positive");
	end

	logic [W-1:0] e1_q;
	logic [1:0] n_q;
	logic [1:0] n_d;
	wire take = in_valid_i && in_ready_o;
	wire give = out_valid_o && out_ready_i;

	assign n_d = n_q + {1'b0, take} - {1'b0, give};

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			out_data_o <= '0;
			e1_q <= '0;
			n_q <= 2'h0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			n_q <= n_d;
			in_ready_o <= n_d != 2'h2;
			out_valid_o <= n_d != 2'h0;
			if (give && n_q == 2'h2) begin
				out_data_o <= e1_q;
				if (take) begin
					e1_q <= in_data_i;
				end
			end else if (take && (give || n_q == 2'h0)) begin
				out_data_o <= in_data_i;
			end else if (take) begin
				e1_q <= in_data_i;
			end
		end
	end
endmodule // skid_buf2
`default_nettype wire

// ===== shared/bpu_pkg.sv
// constants, states and address arithmetic of the bus interface unit
// assumes: compiled before every design file that names bpu_pkg
package bpu_pkg;

	// ==========================================================
	// sizes
	localparam int ADDR_W = 20;
	localparam int WIDE_QDEPTH = 6;
	localparam int NARROW_QDEPTH = 4;
	localparam logic [3:0] WIDE_MIN_FREE = 4'h2;
	localparam logic [3:0] NARROW_MIN_FREE = 4'h1;
	localparam logic [15:0] WIDE_STEP = 16'h0002;
	localparam logic [15:0] NARROW_STEP = 16'h0001;

	// ==========================================================
	// strap settling: sync depth before the mode is caught
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// ==========================================================
	// maximum mode cycle status codes
	localparam logic [2:0] STS_PASSIVE = 3'h7;
	localparam logic [2:0] STS_FETCH = 3'h4;
	localparam logic [2:0] STS_MEM_RD = 3'h5;
	localparam logic [2:0] STS_MEM_WR = 3'h6;
	localparam logic [2:0] STS_IO_RD = 3'h1;
	localparam logic [2:0] STS_IO_WR = 3'h2;

	// ==========================================================
	// bus cycle states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_T1 = 6'h02,
		ST_T2 = 6'h04,
		ST_T3 = 6'h08,
		ST_TW = 6'h10,
		ST_T4 = 6'h20
	} bus_state_e;

	// segment times sixteen plus offset, wrapping at one megabyte
	function automatic logic [ADDR_W-1:0] phys_addr(
		input logic [15:0] seg,
		input logic [15:0] off
	);
		phys_addr = {seg, 4'h0} + {4'h0, off};
	endfunction

endpackage

// ===== shared/pfq_if.sv
// signals between the bus engine and its instruction byte queue
// assumes: the bus engine fills, the queue module stores
`timescale 1ns/1ns
`default_nettype none
interface pfq_if;
	logic push;
	logic push_two;
	logic [15:0] push_data;
	logic pop;
	logic flush;
	logic [3:0] free;
	logic head_valid;
	logic [7:0] head_byte;
	modport fill (output push, push_two, push_data, pop, flush,
		input free, head_valid, head_byte);
	modport store (input push, push_two, push_data, pop, flush,
		output free, head_valid, head_byte);
endinterface
`default_nettype wire

// ===== sim/bus_mem_model.sv
// memory and port space seen on the multiplexed bus
// assumes: design bus pins on clk_sys_i; wait count set by the bench
`timescale 1ns/1ns
`default_nettype none
module bus_mem_model (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// design bus pins
	input wire logic [15:0] ad_i,
	input wire logic [3:0] hi_i,
	input wire logic bhe_n_i,
	input wire logic ale_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [2:0] sts_i,
	output logic [15:0] ad_o,
	output logic ready_o,
	// bench side
	input wire logic [1:0] waits_i,
	output logic wr_stb_o,
	output logic [19:0] wa_o,
	output logic [15:0] wd_o,
	output logic bhe_n_q_o
);
	logic [19:0] a_q;
	logic [2:0] sts_q;
	logic [1:0] cnt_q;
	logic [1:0] hold_q;
	logic [15:0] last_q;
	logic wr_q;
	wire strobe = !rd_n_i || !wr_n_i;
	// cycle start
	// without the latch strobe the status lines mark the start
	wire open_c = ale_i || (sts_i != bpu_pkg::STS_PASSIVE &&
		sts_q == bpu_pkg::STS_PASSIVE);
	wire act = strobe || open_c;
	// ready and data reach the design two flops late, so both stand
	// from the address state on
	wire [19:0] ca = open_c ? {hi_i, ad_i} : a_q;

	function automatic logic [7:0] mb(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {4'h5, a[19:16]};
	endfunction

	// read data held
	// data stays two edges past the strobe: pins go through two flops;
	// a released bus toggles so a stale value never matches
	assign ad_o = (open_c || !rd_n_i || hold_q != 2'h0) ?
		{mb({ca[19:1], 1'b1}), mb({ca[19:1], 1'b0})} : ~last_q;
	assign ready_o = !act || cnt_q >= waits_i;
	assign wr_stb_o = wr_n_i && !wr_q;
	assign wa_o = a_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			a_q <= 20'h0;
			sts_q <= bpu_pkg::STS_PASSIVE;
			cnt_q <= 2'h0;
			hold_q <= 2'h0;
			last_q <= 16'h0;
			wr_q <= 1'b1;
			wd_o <= 16'h0;
			bhe_n_q_o <= 1'b1;
		end else begin
			sts_q <= sts_i;
			last_q <= ad_o;
			wr_q <= wr_n_i;
			cnt_q <= act ? cnt_q + {1'b0, cnt_q != 2'h3} : 2'h0;
			hold_q <= !rd_n_i ? 2'h2 : hold_q - {1'b0, hold_q != 2'h0};
			if (open_c) begin
				a_q <= {hi_i, ad_i};
			end
			if (!wr_n_i) begin
				wd_o <= ad_i;
				bhe_n_q_o <= bhe_n_i;
			end
		end
	end
endmodule // bus_mem_model
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the bus interface unit, wide variant
// assumes: bus_mem_model stands on the bus pins
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk_sys_i, rst_i, bus_mode_strap_i, ready_i, ad_oe_o, bhe_n_o;
	logic den_n_o, dt_r_o, mem_io_o, ad_hi_oe_o;
	logic [15:0] ad_i, ad_o, jump_seg_i, jump_off_i, req_seg_i, req_off_i;
	logic [15:0] req_wdata_i, rsp_data_o, wd;
	logic [3:0] addr_hi_o;
	logic [2:0] status_o;
	logic ale_o, rd_n_o, wr_n_o, ctl_oe_o, fetch_valid_o, fetch_ready_i;
	logic jump_i, req_valid_i, req_ready_o, req_write_i, req_io_i;
	logic req_word_i, rsp_valid_o, rsp_ready_i, wr_stb, bq, stall;
	logic [7:0] fetch_byte_o;
	logic [1:0] waits;
	logic [19:0] wa;
	logic [15:0] fs, fo;
	wire [19:0] fa = {fs, 4'h0} + {4'h0, fo};
	logic [15:0] rq[$];
	logic [53:0] wq[$];
	logic [53:0] we;
	int seed = 46106;
	int bad_count = 0;
	int checked = 0;
	int alec = 0;
	int n;

	bus_interface_prefetch_unit bus_interface_prefetch_unit_inst (.*);
	bus_mem_model bus_mem_model_inst (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .ad_i(ad_o), .hi_i(addr_hi_o), .bhe_n_i(bhe_n_o),
		.ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .sts_i(status_o),
		.ad_o(ad_i), .ready_o(ready_i), .waits_i(waits),
		.wr_stb_o(wr_stb), .wa_o(wa), .wd_o(wd), .bhe_n_q_o(bq));

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// ==========================================================
	// checking
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// drivers
	task automatic req(input logic w, io, wd, input logic [15:0] s, o, d);
		logic [19:0] a;
		logic ev;
		a = io ? {4'h0, o} : {s, 4'h0} + {4'h0, o};
		ev = wd && !a[0];
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		{req_write_i, req_io_i, req_word_i} <= {w, io, wd};
		{req_seg_i, req_off_i, req_wdata_i} <= {s, o, d};
		@(posedge clk_sys_i);
		for (int i = 0; req_ready_o !== 1'b1 && i < 300; i++)
			@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		rq.push_back(w ? 16'h0 : ev ? {bus_mem_model_inst.mb(a + 20'h1),
			bus_mem_model_inst.mb(a)} : {8'h0, bus_mem_model_inst.mb(a)});
		if (w)
			wq.push_back({!io, a, ev ? 16'hffff : a[0] ? 16'hff00 : 16'h00ff,
				ev ? d : a[0] ? {d[7:0], 8'h0} : {8'h0, d[7:0]}, !(ev || a[0])});
	endtask

	task automatic jmp(input logic [15:0] s, o);
		@(posedge clk_sys_i);
		jump_i <= 1'b1;
		{jump_seg_i, jump_off_i} <= {s, o};
		@(posedge clk_sys_i);
		jump_i <= 1'b0;
	endtask

	// receiver stalls at random on both answer paths
	always @(posedge clk_sys_i) begin
		fetch_ready_i <= !stall && $random(seed) % 4 != 0;
		rsp_ready_i <= $random(seed) % 3 != 0;
	end

	// ==========================================================
	// monitor
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			{fs, fo} <= 32'h0;
			rq.delete();
			wq.delete();
		end else begin
			alec <= alec + int'(ale_o === 1'b1);
			if (rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1)
				check(20'(rsp_data_o), 20'(rq.pop_front()));
			if (fetch_valid_o === 1'b1 && fetch_ready_i === 1'b1) begin
				check(20'(fetch_byte_o), 20'(bus_mem_model_inst.mb(fa)));
				fo <= fo + 16'h1;
			end
			if (jump_i)
				{fs, fo} <= {jump_seg_i, jump_off_i};
			if (rd_n_o === 1'b0 && ctl_oe_o === 1'b1)
				check(20'({den_n_o, dt_r_o, ad_hi_oe_o}), 20'h0);
			if (wr_n_o === 1'b0)
				check(20'({den_n_o, dt_r_o, ad_hi_oe_o}), 20'h3);
			if (wr_stb === 1'b1) begin
				we = wq.pop_front();
				check(wa, we[52:33]);
				check(20'(wd & we[32:17]), 20'(we[16:1]));
				check(20'(bq), 20'(we[0]));
				check(20'(mem_io_o), 20'(we[53]));
			end
		end
	end

	initial begin
		#400000;
		bad_count++;
		stop_test();
	end

	// ==========================================================
	// scenarios
	initial begin
		{rst_i, bus_mode_strap_i, stall} = 3'b110;
		{jump_i, req_valid_i, fetch_ready_i, rsp_ready_i} = 4'h0;
		{req_write_i, req_io_i, req_word_i} = 3'h0;
		{jump_seg_i, jump_off_i, req_seg_i, req_off_i, req_wdata_i} = '0;
		waits = 2'h0;
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		check(20'(ctl_oe_o), 20'h1);
		// mixed traffic, wait states and jumps to odd or even targets
		for (int i = 0; i < 30; i++) begin
			waits <= 2'($random(seed));
			if (i % 5 == 4)
				jmp(16'($random(seed)), 16'($random(seed)));
			req(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
				16'($random(seed)), 16'($random(seed)), 16'($random(seed)));
		end
		// full queue leaves the bus idle; a jump refills exactly one queue
		stall = 1'b1;
		repeat (60) @(posedge clk_sys_i);
		n = alec;
		jmp(16'h0123, 16'h0040);
		repeat (60) @(posedge clk_sys_i);
		check(20'(alec - n), 20'(bpu_pkg::WIDE_QDEPTH / 2));
		check(20'(rq.size()), 20'h0);
		stall = 1'b0;
		// reset with a request pending, then maximum mode
		req(1'b0, 1'b0, 1'b1, 16'h2000, 16'h0010, 16'h0);
		rst_i <= 1'b1;
		bus_mode_strap_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		check(20'(fetch_valid_o), 20'h0);
		rst_i <= 1'b0;
		n = alec;
		for (int i = 0; i < 6; i++)
			req(1'b0, 1'(i), 1'b1, 16'($random(seed)), 16'($random(seed)), 16'h0);
		repeat (80) @(posedge clk_sys_i);
		check(20'(ctl_oe_o), 20'h0);
		check(20'(alec - n), 20'h0);
		check(20'(rq.size()), 20'h0);
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
